// [core/odt_output_delay_element.sv]
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
// What this block does
// - One delay line with 512 selectable taps
// - Input from fabric, flip-flop or serializer
// - Tap-count format runs uncalibrated, no controller
// - Tap-count initial setting is taps 0..511
// - Time format needs controller, holds ps delay
// - Optional local control clock inversion
// - Step enable moves tap by one per clock
// - Step enable low keeps tap unchanged
// - Stepping starts and stops on next edge, one edge later with the control clock inverted
// - Tap wraps at both ends of line
// - Load strobe reloads from setting or bus
// - Loadable mode load copies nine-bit input
// - Tap change applies within three clocks
// - Reset clears the initial setting and the tap to zero
// - Nine-bit tap value output bus
module odt_output_delay_element
    import odt_pkg::*;
(
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ODT_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Tap control from fabric logic
    input  wire logic                  load,
    input  wire logic                  step_enable,
    input  wire logic                  step_up,
    input  wire logic [ODT_TAP_W-1:0]  tap_value_input,
    output logic      [ODT_TAP_W-1:0]  tap_value_output,
    // Compensation and calibration controller
    input  wire logic                  vt_compensation_enable,
    input  wire logic                  calib_ready,
    // Data path
    input  wire logic                  data_in,
    output logic                       delayed_output,
    // Cascade
    input  wire logic                  cascade_input,
    input  wire logic                  cascade_return,
    output logic                       cascade_output
);

    ////////////////////////////////////////////////////////////////////////////
    // Conversion of the configured setting into taps

    // Tap count as is, picoseconds divided by nominal tap step
    function automatic logic [ODT_TAP_W-1:0] odt_init_taps(input logic [ODT_PS_W-1:0] setting,
                                                           input logic                fmt_time);
        logic [ODT_PS_W-1:0] q;
        q = setting / ODT_TAP_PS;
        if (fmt_time) begin
            odt_init_taps = q[ODT_TAP_W-1:0];
        end else begin
            odt_init_taps = setting[ODT_TAP_W-1:0];
        end
    endfunction

    // Read word of the addressed register, zero for an unmapped address
    function automatic logic [31:0] odt_rd_sel(input logic [ODT_ADDR_W-1:0] addr,
                                               input logic [31:0]           w_ctrl,
                                               input logic [31:0]           w_init,
                                               input logic [31:0]           w_stat);
        if (addr == ODT_ADDR_CTRL) begin
            odt_rd_sel = w_ctrl;
        end else if (addr == ODT_ADDR_INIT) begin
            odt_rd_sel = w_init;
        end else if (addr == ODT_ADDR_STAT) begin
            odt_rd_sel = w_stat;
        end else begin
            odt_rd_sel = 32'h00000000;
        end
    endfunction

    // Filtered level moves only when the second and third stages agree
    function automatic logic odt_settle(input logic [2:0] sync,
                                        input logic       cur);
        if (sync[1] == sync[2]) begin
            odt_settle = sync[2];
        end else begin
            odt_settle = cur;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [5:0]           ctrl_r;
    logic [ODT_PS_W-1:0]  init_r;
    logic [ODT_TAP_W-1:0] tap_r;
    logic [ODT_TAP_W-1:0] tap_nxt;
    logic [ODT_TAP_W-1:0] tap_p1_r;
    logic [ODT_TAP_W-1:0] tap_app_r;
    logic                 line_r [0:ODT_TAPS-1];
    logic [2:0]           vt_sync_r;
    logic [2:0]           rdy_sync_r;
    logic [2:0]           ret_sync_r;
    logic                 vt_f_r;
    logic                 rdy_f_r;
    logic                 ret_f_r;
    logic                 load_q_r;
    logic                 step_q_r;
    logic                 up_q_r;
    logic [ODT_TAP_W-1:0] tvin_q_r;
    logic [31:0]          prdata_r;
    logic                 pready_r;
    logic                 pslverr_r;
    logic                 delayed_r;
    logic                 cascade_output_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    wire                  acc_phase  = psel & penable & ~pready_r;
    wire                  acc_done   = psel & penable & pready_r;
    wire                  hit_ctrl   = (paddr == ODT_ADDR_CTRL);
    wire                  hit_init   = (paddr == ODT_ADDR_INIT);
    wire                  hit_stat   = (paddr == ODT_ADDR_STAT);
    wire                  hit_any    = hit_ctrl | hit_init | hit_stat;
    wire                  wr_ctrl    = acc_done & pwrite & hit_ctrl;
    wire                  wr_init    = acc_done & pwrite & hit_init;

    wire odt_mode_t       mode       = odt_mode_t'(ctrl_r[ODT_CTRL_MODE_LSB +: 2]);
    wire                  fmt_time   = ctrl_r[ODT_CTRL_FMT_BIT];
    wire                  clk_inv    = ctrl_r[ODT_CTRL_INV_BIT];
    wire odt_casc_t       casc       = odt_casc_t'(ctrl_r[ODT_CTRL_CASC_LSB +: 2]);
    wire [ODT_TAP_W-1:0]  init_taps  = odt_init_taps(init_r, fmt_time);
    wire                  calib_miss = fmt_time & ~rdy_f_r;

    // Read data for the addressed register
    wire [31:0]           rd_ctrl    = {26'h0000000, ctrl_r};
    wire [31:0]           rd_init    = {21'h000000, init_r};
    wire [31:0]           rd_stat    = {rdy_f_r, calib_miss, 5'h00, tap_app_r, 7'h00, tap_r};
    wire [31:0]           rd_mux     = odt_rd_sel(paddr, rd_ctrl, rd_init, rd_stat);

    ////////////////////////////////////////////////////////////////////////////
    // Control sampling

    // Inverted control clock takes the copy held from the opposite edge
    wire                  c_load     = clk_inv ? load_q_r    : load;
    wire                  c_step     = clk_inv ? step_q_r    : step_enable;
    wire                  c_up       = clk_inv ? up_q_r      : step_up;
    wire [ODT_TAP_W-1:0]  c_tvin     = clk_inv ? tvin_q_r    : tap_value_input;

    // Controls act only in step and loadable modes; time format waits for the controller
    wire                  var_mode   = (mode == ODT_STEP) || (mode == ODT_LOADABLE);
    wire                  user_ok    = var_mode & ~(fmt_time & (vt_f_r | ~rdy_f_r));

    ////////////////////////////////////////////////////////////////////////////
    // Tap counter next value

    always_comb begin
        tap_nxt = tap_r;
        if (!var_mode) begin
            tap_nxt = init_taps;
        end else if (user_ok && c_load) begin
            if (mode == ODT_LOADABLE) begin
                tap_nxt = c_tvin;
            end else begin
                tap_nxt = init_taps;
            end
        end else if (user_ok && c_step) begin
            if (c_up) begin
                tap_nxt = tap_r + 9'h001;
            end else begin
                tap_nxt = tap_r - 9'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= ODT_CTRL_RST;
            init_r <= ODT_INIT_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= pwdata[5:0];
            end
            if (wr_init) begin
                init_r <= pwdata[ODT_PS_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state, error on unmapped address

    // Ready falls after one cycle, so a held access is answered again every second cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= acc_phase;
            pslverr_r <= acc_phase & ~hit_any;
            if (acc_phase && !pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage synchronisers for asynchronous inputs

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vt_sync_r  <= 3'h0;
            rdy_sync_r <= 3'h0;
            ret_sync_r <= 3'h0;
        end else begin
            vt_sync_r  <= {vt_sync_r[1:0], vt_compensation_enable};
            rdy_sync_r <= {rdy_sync_r[1:0], calib_ready};
            ret_sync_r <= {ret_sync_r[1:0], cascade_return};
        end
    end

    // A change counts once the second and third stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vt_f_r  <= 1'b0;
            rdy_f_r <= 1'b0;
            ret_f_r <= 1'b0;
        end else begin
            vt_f_r  <= odt_settle(vt_sync_r, vt_f_r);
            rdy_f_r <= odt_settle(rdy_sync_r, rdy_f_r);
            ret_f_r <= odt_settle(ret_sync_r, ret_f_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Opposite-edge copies of the controls

    // Sampling one cycle later stands in for the inverted edge in one clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_q_r <= 1'b0;
            step_q_r <= 1'b0;
            up_q_r   <= 1'b0;
            tvin_q_r <= 9'h000;
        end else begin
            load_q_r <= load;
            step_q_r <= step_enable;
            up_q_r   <= step_up;
            tvin_q_r <= tap_value_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tap counter and apply pipeline

    // Reset value matches the reset initial setting
    // Two-stage apply pipeline lets the line settle before its select moves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_r     <= ODT_INIT_RST[ODT_TAP_W-1:0];
            tap_p1_r  <= ODT_INIT_RST[ODT_TAP_W-1:0];
            tap_app_r <= ODT_INIT_RST[ODT_TAP_W-1:0];
        end else begin
            tap_r     <= tap_nxt;
            tap_p1_r  <= tap_r;
            tap_app_r <= tap_p1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delay line: one sample per tap, indexed by the applied tap

    // Slave role takes the cascade input instead of local data
    wire                  line_src   = (casc == ODT_CASC_SLAVE) ? cascade_input : data_in;

    // Reset clears the line so stale data never reaches the pad
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ODT_TAPS; i++) begin
                line_r[i] <= 1'b0;
            end
        end else begin
            line_r[0] <= line_src;
            for (int i = 1; i < ODT_TAPS; i++) begin
                line_r[i] <= line_r[i-1];
            end
        end
    end

    wire                  tap_out    = line_r[tap_app_r];

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Master role drives the chain and returns the slave's delayed data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delayed_r  <= 1'b0;
            cascade_output_r <= 1'b0;
        end else begin
            cascade_output_r <= (casc == ODT_CASC_MASTER) ? tap_out : 1'b0;
            delayed_r  <= (casc == ODT_CASC_MASTER) ? ret_f_r : tap_out;
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign tap_value_output = tap_r;
    assign delayed_output   = delayed_r;
    assign cascade_output   = cascade_output_r;

endmodule

// [core/odt_pkg.sv]
package odt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Delay line geometry
    localparam int          ODT_TAPS       = 512;
    localparam int          ODT_TAP_W      = 9;
    localparam logic [8:0]  ODT_TAP_LAST   = 9'h1FF;
    localparam int          ODT_APPLY_LAT  = 3;        // Cycles from tap change to delayed output

    ////////////////////////////////////////////////////////////////////////////
    // Time format: picosecond setting converted with a nominal tap step
    localparam int          ODT_PS_W       = 11;
    localparam logic [10:0] ODT_TAP_PS     = 11'h003;  // Nominal ps per tap, plain default

    ////////////////////////////////////////////////////////////////////////////
    // APB register map (byte addresses)
    localparam int          ODT_ADDR_W     = 12;
    localparam logic [11:0] ODT_ADDR_CTRL  = 12'h000;
    localparam logic [11:0] ODT_ADDR_INIT  = 12'h004;
    localparam logic [11:0] ODT_ADDR_STAT  = 12'h008;

    // Control register fields
    localparam int          ODT_CTRL_MODE_LSB = 0;     // [1:0] delay mode
    localparam int          ODT_CTRL_FMT_BIT  = 2;     // 0 tap count, 1 picoseconds
    localparam int          ODT_CTRL_INV_BIT  = 3;     // Sample controls on opposite edge
    localparam int          ODT_CTRL_CASC_LSB = 4;     // [5:4] cascade role
    localparam logic [5:0]  ODT_CTRL_RST      = 6'h00;

    // Initial delay register: taps [8:0] or ps [10:0]
    localparam logic [10:0] ODT_INIT_RST   = 11'h000;

    // Status register fields
    localparam int          ODT_STAT_TAP_LSB  = 0;     // [8:0] counter value
    localparam int          ODT_STAT_APP_LSB  = 16;    // [24:16] tap now selecting the line
    localparam int          ODT_STAT_CALM_BIT = 30;    // Time format without ready controller
    localparam int          ODT_STAT_RDY_BIT  = 31;    // Calibration controller ready

    ////////////////////////////////////////////////////////////////////////////
    // Modes and cascade roles
    typedef enum logic [1:0] {
        ODT_FIXED     = 2'b00,
        ODT_STEP      = 2'b01,
        ODT_LOADABLE  = 2'b10
    } odt_mode_t;

    typedef enum logic [1:0] {
        ODT_CASC_NONE   = 2'b00,
        ODT_CASC_MASTER = 2'b01,
        ODT_CASC_SLAVE  = 2'b10
    } odt_casc_t;

endpackage

// [verification/odt_fabric_model.sv]
`timescale 1ns/1ps
module odt_fabric_model
    import odt_pkg::*;
(
    // Clock shared with the delay element
    input wire logic                 pclk,
    // Controls toward the delay element
    output logic                     load,
    output logic                     step_enable,
    output logic                     step_up,
    output logic [ODT_TAP_W-1:0]     tap_value_input,
    output logic                     vt_compensation_enable,
    // Cascade partner: slave input element returning its delayed output
    input wire logic                 cascade_output,
    output logic                     cascade_return
);
    // Idle controls, compensation kept low for tap updates
    initial begin
        load = 1'b0;
        step_enable = 1'b0;
        step_up = 1'b0;
        tap_value_input = 9'h000;
        vt_compensation_enable = 1'b0;
        cascade_return = 1'b0;
    end

    // Slave with zero tap: cascade output comes back one register later
    always @(posedge pclk) begin
        cascade_return <= cascade_output;
    end

    // Bus first, strobe one cycle later, step held off throughout
    task automatic do_load(input logic [ODT_TAP_W-1:0] val);
        @(posedge pclk);
        tap_value_input <= val;
        step_enable <= 1'b0;
        @(posedge pclk);
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        tap_value_input <= ~val; // Bus no longer meaningful after the load
    endtask

    // Enable held for n edges gives n steps
    task automatic do_step(input logic up, input int n);
        @(posedge pclk);
        step_up <= up;
        step_enable <= 1'b1;
        repeat (n) @(posedge pclk);
        step_enable <= 1'b0;
        step_up <= ~up; // Direction is a don't-care while idle
    endtask
endmodule

// [verification/odt_output_delay_element_tb.sv]
`timescale 1ns/1ps
module odt_output_delay_element_tb;
    import odt_pkg::*;
    // Design signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic data_in = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, load, step_enable, step_up, vt_compensation_enable, delayed_output;
    logic [8:0] tap_value_input, tap_value_output;
    logic cascade_output, cascade_return;
    logic calib_ready = 1'b0;
    logic data_lvl = 1'b0;
    // Bench state
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    int seed = 59739;
    logic data_en = 1'b0;
    logic [1023:0] hist = '0;
    logic [31:0] rd;
    logic er;
    logic [8:0] v, exp_tap;
    logic up;
    int n;

    odt_output_delay_element i_odt_output_delay_element (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .load, .step_enable, .step_up, .tap_value_input,
        .tap_value_output, .vt_compensation_enable, .calib_ready, .data_in, .delayed_output,
        .cascade_input(1'b0), .cascade_return, .cascade_output);
    odt_fabric_model i_odt_fabric_model (.pclk, .load, .step_enable, .step_up, .tap_value_input,
        .vt_compensation_enable, .cascade_output, .cascade_return);

    // Clock
    initial begin
        forever #2 pclk = ~pclk;
    end

    // Data history, random data, run limit
    always @(posedge pclk) begin
        hist <= {hist[1022:0], data_in};
        if (data_en) data_in <= 1'($random(seed));
        else data_in <= data_lvl;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    ////////////////////////////////////////
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_tap(input logic [8:0] e);
        @(negedge pclk);
        chk32({23'h0, tap_value_output}, {23'h0, e});
    endtask
    // One APB transfer, answer taken at the edge where pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [8:0] stepped(input logic [8:0] t, input logic u, input int k);
        return u ? t + 9'(k) : t - 9'(k);
    endfunction
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk_tap(9'h000);
        apb(1'b0, ODT_ADDR_INIT, 32'h0);
        chk32(rd, 32'h0);
        apb(1'b1, 12'h00C, 32'hFFFFFFFF);
        chk32({31'h0, er}, 32'h1);
        apb(1'b1, ODT_ADDR_STAT, 32'h1FF);
        apb(1'b0, ODT_ADDR_STAT, 32'h0);
        chk32({23'h0, rd[8:0]}, 32'h0);
        $display("test registers done");
        // Fixed mode follows the initial setting, including the last tap
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 9'h1FF : 9'($random(seed));
            apb(1'b1, ODT_ADDR_INIT, {23'h0, v});
            repeat (4) @(posedge pclk);
            chk_tap(v);
            apb(1'b0, ODT_ADDR_STAT, 32'h0);
            chk32({23'h0, rd[8:0]}, {23'h0, v});
        end
        $display("test fixed done");
        exp_tap = v;
        // Step mode with load tied low, then loadable mode
        for (int m = 1; m < 3; m++) begin
            apb(1'b1, ODT_ADDR_CTRL, 32'(m));
            if (m == 2) begin
                for (int i = 0; i < 5; i++) begin
                    v = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
                    i_odt_fabric_model.do_load(v);
                    chk_tap(v);
                    apb(1'b0, ODT_ADDR_STAT, 32'h0);
                    chk32({23'h0, rd[24:16]}, {23'h0, v});
                end
                i_odt_fabric_model.do_load(9'h1FE);
                i_odt_fabric_model.do_step(1'b1, 3);
                chk_tap(9'h001);
                i_odt_fabric_model.do_step(1'b0, 3);
                repeat (8) @(posedge pclk);
                chk_tap(9'h1FE);
                exp_tap = 9'h1FE;
            end
            for (int i = 0; i < 10; i++) begin
                up = 1'($random(seed));
                n = 1 + ($random(seed) & 7);
                i_odt_fabric_model.do_step(up, n);
                exp_tap = stepped(exp_tap, up, n);
                chk_tap(exp_tap);
            end
            $display("test stepping done");
        end
        // Output follows input by tap plus pipeline, at taps 3 and 511
        apb(1'b1, ODT_ADDR_CTRL, 32'(ODT_FIXED));
        for (int t = 3; t < 512; t += 508) begin
            apb(1'b1, ODT_ADDR_INIT, 32'(t));
            repeat (8) @(posedge pclk);
            data_en <= 1'b1;
            repeat (t + 8) @(posedge pclk);
            repeat (40) begin
                @(negedge pclk);
                chk32({31'h0, delayed_output}, {31'h0, hist[t + 1]});
                chk32({31'h0, cascade_output}, 32'h0);
            end
            data_en <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        $display("test delay line done");
        // Master role: data leaves on the cascade and comes back from the slave
        apb(1'b1, ODT_ADDR_CTRL, 32'(ODT_CASC_MASTER) << ODT_CTRL_CASC_LSB);
        apb(1'b1, ODT_ADDR_INIT, 32'h4);
        for (int b = 1; b >= 0; b--) begin
            @(posedge pclk);
            data_lvl <= 1'(b);
            repeat (24) @(posedge pclk);
            @(negedge pclk);
            chk32({31'h0, cascade_output}, 32'(b));
            chk32({31'h0, delayed_output}, 32'(b));
        end
        $display("test cascade done");
        // Time format: setting in picoseconds, controls wait for the controller
        apb(1'b1, ODT_ADDR_CTRL, 32'h4);
        apb(1'b1, ODT_ADDR_INIT, 32'h12C);
        exp_tap = 9'(11'h12C / ODT_TAP_PS);
        repeat (4) @(posedge pclk);
        chk_tap(exp_tap);
        apb(1'b1, ODT_ADDR_CTRL, 32'h5);
        apb(1'b0, ODT_ADDR_STAT, 32'h0);
        chk32({30'h0, rd[31:30]}, 32'h1);
        i_odt_fabric_model.do_step(1'b1, 4);
        chk_tap(exp_tap);
        @(posedge pclk);
        calib_ready <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, ODT_ADDR_STAT, 32'h0);
        chk32({30'h0, rd[31:30]}, 32'h2);
        i_odt_fabric_model.do_step(1'b1, 4);
        exp_tap = stepped(exp_tap, 1'b1, 4);
        chk_tap(exp_tap);
        // Inverted control clock: the same steps land one edge later
        apb(1'b1, ODT_ADDR_CTRL, 32'h9);
        i_odt_fabric_model.do_step(1'b0, 3);
        exp_tap = stepped(exp_tap, 1'b0, 3);
        @(posedge pclk);
        chk_tap(exp_tap);
        $display("test time format done");
        // Reset in mid-run returns the tap to zero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk_tap(9'h000);
        $display("test reset done");
        print_verdict();
    end
endmodule

bind odt_output_delay_element odt_checker i_odt_checker (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .load, .step_enable, .step_up, .tap_value_input,
    .tap_value_output);

// [verification/odt_properties.sv]
`timescale 1ns/1ps
module odt_checker
    import odt_pkg::*;
(
    // Clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // APB
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ODT_ADDR_W-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Tap control
    input wire logic                  load,
    input wire logic                  step_enable,
    input wire logic                  step_up,
    input wire logic [ODT_TAP_W-1:0]  tap_value_input,
    input wire logic [ODT_TAP_W-1:0]  tap_value_output
);
    ////////////////////////////////////////
    // Shadow of control bits, mode known only outside a control write
    logic [3:0] ctrl_r;
    wire ctrl_wr = psel && penable && pready && pwrite && paddr == ODT_ADDR_CTRL;
    wire loadable = ctrl_r[1:0] == ODT_LOADABLE;
    wire var_m = (ctrl_r[1:0] == ODT_STEP || loadable) && ctrl_r[3:2] == 2'h0 && !ctrl_wr;
    wire mapped = paddr == ODT_ADDR_CTRL || paddr == ODT_ADDR_INIT || paddr == ODT_ADDR_STAT;

    // Track control writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctrl_r <= 4'h0;
        else if (ctrl_wr) ctrl_r <= pwdata[3:0];
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Steps of one operation
    sequence s_step(up);
        var_m && !load && step_enable && step_up == up;
    endsequence
    sequence s_access;
        psel && penable && !pready;
    endsequence

    ////////////////////////////////////////
    a_step_inc_one: assert property (s_step(1'b1) |=>
        tap_value_output == $past(tap_value_output) + 9'h001) else $error("tap did not rise by one");
    a_step_dec_one: assert property (s_step(1'b0) |=>
        tap_value_output == $past(tap_value_output) - 9'h001) else $error("tap did not fall by one");
    a_idle_tap_hold: assert property (var_m && !load && !step_enable |=>
        $stable(tap_value_output)) else $error("tap moved while idle");
    a_load_copies_bus: assert property (var_m && loadable && load |=>
        tap_value_output == $past(tap_value_input)) else $error("load did not copy bus");
    a_reset_tap_zero: assert property ($rose(presetn) |-> tap_value_output == 9'h000)
        else $error("tap not at setting after reset");
    a_apb_answer_next: assert property (s_access |=> pready) else $error("no answer");
    a_apb_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_apb_err_unmapped: assert property (pready |-> pslverr == !mapped) else $error("bad error flag");
endmodule
